// file: rtl/outctl_pkg.sv
// Notes on behaviour
// - Rate-search auto-mute bit 5 set: output b mutes while recovery lacks lock.
// - Rate-search auto-mute bit 4 set: output a mutes while recovery lacks lock.
// - Manual mode: bit 3 mutes output b when 1, unmutes when 0.
// - Bit 2 picks automatic (1) or manual (0) mute for output b; resets 1.
// - Manual mode: bit 1 mutes output a when 1, unmutes when 0.
// - Bit 0 picks automatic (1) or manual (0) mute for output a; resets 1.
// - Manual mode: disable bit 3 powers down output b when 1.
// - Disable bit 2 picks automatic (1) or manual (0) for output b; resets 0.
// - Manual mode: disable bit 1 powers down output a when 1.
// - Disable bit 0 picks automatic (1) or manual (0) for output a; resets 0.
package outctl_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam logic [7:0] MUTE_IDX = 8'h49;
   localparam logic [7:0] DIS_IDX = 8'h4A;
   localparam int MUTE_BITS = 6;
   localparam int DIS_BITS = 4;
   localparam int A_MODE_BIT = 0;
   localparam int A_MAN_BIT = 1;
   localparam int B_MODE_BIT = 2;
   localparam int B_MAN_BIT = 3;
   localparam int A_RS_BIT = 4;
   localparam int B_RS_BIT = 5;
   localparam logic [5:0] MUTE_RST = 6'h05;
   localparam logic [3:0] DIS_RST = 4'h0;
   localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h0000_0000;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } bus_state_t;

   function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
      return ADDR_W'({idx, 2'b00} >> 0);
   endfunction
endpackage

// file: rtl/out_decide.sv
`timescale 1ns/1ps
`default_nettype none
module out_decide (
   // Register fields for one output.
   input wire logic mute_mode_i,
   input wire logic manual_mute_i,
   input wire logic rs_mute_i,
   input wire logic pd_mode_i,
   input wire logic manual_pd_i,
   // Link status.
   input wire logic cdr_lock_i,
   input wire logic los_i,
   // Decisions.
   output logic mute_o,
   output logic pd_o
);
   // Manual bit decides in manual mode; loss of signal drives automatic mode; rate-search mute without lock ORs into mute_o.
   assign mute_o = (mute_mode_i ? los_i : manual_mute_i)
      | (rs_mute_i & ~cdr_lock_i);
   assign pd_o = pd_mode_i ? los_i : manual_pd_i;
endmodule
`default_nettype wire

// file: rtl/wb_ack_gen.sv
`timescale 1ns/1ps
`default_nettype none
module wb_ack_gen
   import outctl_pkg::*;
(
   // Clock, reset and enable.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Bus request and answer.
   input wire logic req_i,
   output logic ack_o
);
   typedef struct packed {
      bus_state_t st;
   } ack_state_t;
   ack_state_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      case (s_r.st)
         BUS_IDLE: begin
            if (req_i) begin
               s_nxt.st = BUS_ACK;
            end
         end
         BUS_ACK: begin
            s_nxt.st = BUS_IDLE;
         end
         default: begin
            s_nxt.st = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '{st: BUS_IDLE};
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   assign ack_o = (s_r.st == BUS_ACK);
endmodule
`default_nettype wire

// file: rtl/output_mute_disable_control.sv
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module output_mute_disable_control
   import outctl_pkg::*;
(
   // Clock, reset and enable.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [DATA_W-1:0] wb_dat_i,
   output logic [DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Link status.
   input wire logic cdr_lock_i,
   input wire logic los_i,
   // Driver controls.
   output logic serial_out_a_mute_o,
   output logic serial_out_a_pd_o,
   output logic serial_out_b_mute_o,
   output logic serial_out_b_pd_o
);
   typedef struct packed {
      logic [MUTE_BITS-1:0] mute;
      logic [DIS_BITS-1:0] dis;
      logic [DATA_W-1:0] rdat;
      logic a_mute;
      logic a_pd;
      logic b_mute;
      logic b_pd;
   } core_state_t;
   core_state_t s_r, s_nxt;

   logic req;
   logic ack;
   logic take;
   logic a_mute_w, a_pd_w, b_mute_w, b_pd_w;
   logic hit_mute, hit_dis;

   assign req = wb_cyc_i & wb_stb_i & ~ack;
   assign take = req & ce_i;
   assign hit_mute = (wb_adr_i == byte_addr(MUTE_IDX));
   assign hit_dis = (wb_adr_i == byte_addr(DIS_IDX));

   wb_ack_gen u_ack (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .req_i(req),
      .ack_o(ack)
   );

   out_decide u_a (
      .mute_mode_i(s_r.mute[A_MODE_BIT]),
      .manual_mute_i(s_r.mute[A_MAN_BIT]),
      .rs_mute_i(s_r.mute[A_RS_BIT]),
      .pd_mode_i(s_r.dis[A_MODE_BIT]),
      .manual_pd_i(s_r.dis[A_MAN_BIT]),
      .cdr_lock_i(cdr_lock_i),
      .los_i(los_i),
      .mute_o(a_mute_w),
      .pd_o(a_pd_w)
   );

   out_decide u_b (
      .mute_mode_i(s_r.mute[B_MODE_BIT]),
      .manual_mute_i(s_r.mute[B_MAN_BIT]),
      .rs_mute_i(s_r.mute[B_RS_BIT]),
      .pd_mode_i(s_r.dis[B_MODE_BIT]),
      .manual_pd_i(s_r.dis[B_MAN_BIT]),
      .cdr_lock_i(cdr_lock_i),
      .los_i(los_i),
      .mute_o(b_mute_w),
      .pd_o(b_pd_w)
   );

   always_comb begin
      s_nxt = s_r;
      s_nxt.a_mute = a_mute_w;
      s_nxt.a_pd = a_pd_w;
      s_nxt.b_mute = b_mute_w;
      s_nxt.b_pd = b_pd_w;
      if (req) begin
         // Only the low byte holds live bits; reserved bits stay zero.
         if (hit_mute) begin
            s_nxt.rdat = DATA_W'(s_r.mute);
            if (wb_we_i && wb_sel_i[0]) begin
               s_nxt.mute = wb_dat_i[MUTE_BITS-1:0];
            end
         end else if (hit_dis) begin
            s_nxt.rdat = DATA_W'(s_r.dis);
            if (wb_we_i && wb_sel_i[0]) begin
               s_nxt.dis = wb_dat_i[DIS_BITS-1:0];
            end
         end else begin
            s_nxt.rdat = UNMAPPED_RD;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r.mute <= MUTE_RST;
         s_r.dis <= DIS_RST;
         s_r.rdat <= UNMAPPED_RD;
         s_r.a_mute <= 1'b1;
         s_r.a_pd <= 1'b0;
         s_r.b_mute <= 1'b1;
         s_r.b_pd <= 1'b0;
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = s_r.rdat;
   assign serial_out_a_mute_o = s_r.a_mute;
   assign serial_out_a_pd_o = s_r.a_pd;
   assign serial_out_b_mute_o = s_r.b_mute;
   assign serial_out_b_pd_o = s_r.b_pd;

   a_rs_mute_b: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_r.mute[B_RS_BIT] && !cdr_lock_i |=> serial_out_b_mute_o)
      else $error("Output b not muted without lock.");
   a_rs_mute_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_r.mute[A_RS_BIT] && !cdr_lock_i |=> serial_out_a_mute_o)
      else $error("Output a not muted without lock.");
   a_man_mute_b: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !s_r.mute[B_MODE_BIT] && !s_r.mute[B_RS_BIT]
      |=> serial_out_b_mute_o == $past(s_r.mute[B_MAN_BIT]))
      else $error("Output b manual mute wrong.");
   a_auto_mute_b: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_r.mute[B_MODE_BIT] && los_i |=> serial_out_b_mute_o)
      else $error("Output b auto mute missing.");
   a_man_mute_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !s_r.mute[A_MODE_BIT] && !s_r.mute[A_RS_BIT]
      |=> serial_out_a_mute_o == $past(s_r.mute[A_MAN_BIT]))
      else $error("Output a manual mute wrong.");
   a_auto_mute_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_r.mute[A_MODE_BIT] && !los_i && !s_r.mute[A_RS_BIT]
      |=> !serial_out_a_mute_o)
      else $error("Output a muted with signal present.");
   a_man_pd_b: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !s_r.dis[B_MODE_BIT] |=> serial_out_b_pd_o == $past(s_r.dis[B_MAN_BIT]))
      else $error("Output b manual power down wrong.");
   a_auto_pd_b: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_r.dis[B_MODE_BIT] |=> serial_out_b_pd_o == $past(los_i))
      else $error("Output b auto power down wrong.");
   a_man_pd_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !s_r.dis[A_MODE_BIT] |=> serial_out_a_pd_o == $past(s_r.dis[A_MAN_BIT]))
      else $error("Output a manual power down wrong.");
   a_auto_pd_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_r.dis[A_MODE_BIT] |=> serial_out_a_pd_o == $past(los_i))
      else $error("Output a auto power down wrong.");
   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("Ack held longer than one cycle.");
   a_auto_clr_b: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_r.mute[B_MODE_BIT] && !los_i && !s_r.mute[B_RS_BIT]
      |=> !serial_out_b_mute_o)
      else $error("Output b muted with signal present.");
   a_auto_mute_la: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_r.mute[A_MODE_BIT] && los_i |=> serial_out_a_mute_o)
      else $error("Output a auto mute missing.");
   a_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
      !ce_i |=> $stable(serial_out_a_mute_o) && $stable(serial_out_b_mute_o)
      && $stable(serial_out_a_pd_o) && $stable(serial_out_b_pd_o) && !wb_ack_o)
      else $error("State moved while enable low.");

   c_write_mute: cover property (@(posedge clk_i) wb_ack_o && wb_we_i && hit_mute);
   c_read_dis: cover property (@(posedge clk_i) wb_ack_o && !wb_we_i && hit_dis);
   c_los_pd: cover property (@(posedge clk_i) serial_out_a_pd_o && serial_out_b_pd_o);
   c_rs_mute: cover property (@(posedge clk_i) s_r.mute[B_RS_BIT] && !cdr_lock_i);
   c_ce_hold: cover property (@(posedge clk_i) !ce_i && los_i);
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import outctl_pkg::*;
;
   localparam logic [ADDR_W-1:0] A_MUTE = ADDR_W'({MUTE_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] A_DIS = ADDR_W'({DIS_IDX, 2'b00});
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [ADDR_W-1:0] adr = '0;
   logic [3:0] sel = 4'h0;
   logic [DATA_W-1:0] dat = '0;
   logic [DATA_W-1:0] q;
   logic ack;
   logic ce = 1'b1;
   logic lock = 1'b1;
   logic los = 1'b0;
   logic a_m, a_p, b_m, b_p;
   int n_fail = 0;
   int checks = 0;

   output_mute_disable_control dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack),
      .cdr_lock_i(lock), .los_i(los),
      .serial_out_a_mute_o(a_m), .serial_out_a_pd_o(a_p),
      .serial_out_b_mute_o(b_m), .serial_out_b_pd_o(b_p)
   );

   initial begin
      forever #2 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk(32'h0, 32'h1);
      end
      r = q;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, 4'hF, r);
      chk(r, exp);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      xfer(1'b1, a, d, s, r);
   endtask

   // Writes both registers, sets link status, then checks readback and the four controls.
   task automatic scen(input logic [15:0] m, input logic [15:0] d, input logic lk,
                       input logic ls, input logic [3:0] exp);
      wr(A_MUTE, {16'h0, m}, 4'hF);
      wr(A_DIS, {16'h0, d}, 4'hF);
      @(posedge clk_i);
      lock <= lk;
      los <= ls;
      repeat (3) @(posedge clk_i);
      chk({28'h0, b_m, a_m, b_p, a_p}, {28'h0, exp});
      rd_chk(A_MUTE, {26'h0, m[5:0]});
      rd_chk(A_DIS, {28'h0, d[3:0]});
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      conclude();
   end

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(A_MUTE, 32'h0000_0005);
      rd_chk(A_DIS, 32'h0000_0000);
      scen(16'h0005, 16'h0005, 1'b1, 1'b1, 4'b1111);
      scen(16'h0005, 16'h0005, 1'b1, 1'b0, 4'b0000);
      scen(16'h0000, 16'h0000, 1'b1, 1'b1, 4'b0000);
      scen(16'h0008, 16'h0002, 1'b1, 1'b0, 4'b1001);
      scen(16'h0002, 16'h0008, 1'b1, 1'b0, 4'b0110);
      scen(16'h0001, 16'h0004, 1'b1, 1'b1, 4'b0110);
      scen(16'h0020, 16'h0000, 1'b0, 1'b0, 4'b1000);
      scen(16'h0010, 16'h0000, 1'b0, 1'b0, 4'b0100);
      scen(16'h0030, 16'h0000, 1'b1, 1'b0, 4'b0000);
      // Rate-search bits cleared before lock is lost, as software does for odd rates.
      scen(16'h0000, 16'h0000, 1'b0, 1'b0, 4'b0000);
      wr(A_MUTE, 32'h0000_FFFF, 4'hF);
      rd_chk(A_MUTE, 32'h0000_003F);
      wr(A_DIS, 32'h0000_FFFF, 4'hF);
      rd_chk(A_DIS, 32'h0000_000F);
      wr(A_MUTE, 32'h0000_0000, 4'h0);
      rd_chk(A_MUTE, 32'h0000_003F);
      wr(8'h30, 32'h0000_0000, 4'hF);
      rd_chk(8'h30, UNMAPPED_RD);
      rd_chk(A_DIS, 32'h0000_000F);
      // With the enable low the controls hold although the input signal is lost.
      wr(A_MUTE, 32'h0000_0005, 4'hF);
      wr(A_DIS, 32'h0000_0005, 4'hF);
      @(posedge clk_i);
      lock <= 1'b1;
      los <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk({28'h0, b_m, a_m, b_p, a_p}, 32'h0000_0000);
      ce <= 1'b0;
      los <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk({28'h0, b_m, a_m, b_p, a_p}, 32'h0000_0000);
      ce <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk({28'h0, b_m, a_m, b_p, a_p}, 32'h0000_000F);
      // A second reset in mid-run restores the register and output reset values.
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk({28'h0, b_m, a_m, b_p, a_p}, 32'h0000_000C);
      chk({31'h0, ack}, 32'h0000_0000);
      rst_i <= 1'b0;
      los <= 1'b0;
      rd_chk(A_MUTE, 32'h0000_0005);
      rd_chk(A_DIS, 32'h0000_0000);
      conclude();
   end
endmodule
`default_nettype wire
